// *** common/lintc_defines.vh ***
/*
  Constants of the LIN transceiver channel control block: modes, timing and slope codes.
  Assumes a 200 MHz core clock; included by bare name.
*/
`ifndef LINTC_DEFINES_VH
`define LINTC_DEFINES_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define LINTC_CLK_MHZ        200
`define LINTC_WAKE_MIN_US    30
`define LINTC_WAKE_MAX_US    150
`define LINTC_DOM_TO_MS      20
`define LINTC_WAKE_MIN_CYC   (`LINTC_WAKE_MIN_US * `LINTC_CLK_MHZ)
`define LINTC_WAKE_MAX_CYC   (`LINTC_WAKE_MAX_US * `LINTC_CLK_MHZ)
`define LINTC_DOM_TO_CYC     (`LINTC_DOM_TO_MS * 1000 * `LINTC_CLK_MHZ)

// ----------------------------------------
// Device power modes
// ----------------------------------------
`define LINTC_PM_NORMAL      3'h0
`define LINTC_PM_STOP        3'h1
`define LINTC_PM_SLEEP       3'h2
`define LINTC_PM_RESTART     3'h3
`define LINTC_PM_FAILSAFE    3'h4

// ----------------------------------------
// Channel transceiver modes
// ----------------------------------------
`define LINTC_LM_OFF         2'h0
`define LINTC_LM_WAKE        2'h1
`define LINTC_LM_RXONLY      2'h2
`define LINTC_LM_NORMAL      2'h3

// ----------------------------------------
// Slope codes
// ----------------------------------------
`define LINTC_SLOPE_NORMAL   2'h0
`define LINTC_SLOPE_LOW      2'h1
`define LINTC_SLOPE_FLASH    2'h2

`endif

// *** design/lintc_fifo.v ***
/*
  Parameterised synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module lintc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             clock_i,
  input  wire             nrst_i,
  // Fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ff;
  reg [AW-1:0]    rd_ff;
  reg [AW:0]      cnt_ff;
  wire            push;
  wire            pop;

  assign in_ready_o  = (cnt_ff != DEPTH[AW:0]);
  assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ff];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clock_i) begin
    if (push) begin
      mem[wr_ff] <= in_data_i;
    end
  end

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ff  <= {AW{1'b0}};
      rd_ff  <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ff + 1'b1;
      end
      if (push & ~pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop & ~push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

// *** design/lintc_top.v ***
/*
  LIN transceiver channel control: wake detection, dominant timeouts, undervoltage
  fallback, slope selection, and a transmit FIFO in front of the bus drivers.
  Assumes controller pins and bus levels are asynchronous; modes come from SPI logic.
*/
// Notes on behaviour
// - Bus wake in Stop or Normal raises interrupt and wake source status bit.
// - Bus wake in Stop or Normal drives channel receive output low.
// - Wake in Stop keeps Stop; controller must command Normal itself.
// - Stop wake re-enables a disabled watchdog when watchdog-on-bus-wake enable set.
// - Sleep wake requests Restart then Normal, receive output driven low.
// - Sleep wake raises no interrupt; wake source status still set.
// - Wake dominant phase accepted only between 30 and 150 microseconds.
// - Transmit dominant beyond timeout disables driver, bus held recessive.
// - Transmit timeout sets that channel's own fault flag.
// - Driver re-enabled once transmit input leaves dominant.
// - One control bit disables transmit timeout for all channels.
// - Bus dominant beyond timeout in Normal or Receive Only sets fault flag.
// - Clamp detection leaves the channel mode configuration unchanged.
// - Supply undervoltage forces receive-only: driver off, receiver active.
// - Supply recovery resumes normal channel operation.
// - Low slope for 10.4kBaud, normal slope for 20kBaud; slew only differs.
// - Slope defaults to normal after reset.
// - Low-slope bit takes effect on select rise, for all channels, slope only.
// - Slope setting accepted only in Normal power mode.
// - Flash bit disables slope control from next select rise, Normal mode.
// - Wake needs falling edge, long dominant phase, then rising edge; acts at end.
// - Transmit and bus dominant timeouts are nominally 20 ms.
// - After wake, mode still reads wake-capable and receive output stays low.
// - Wake rearmed by mode toggle or entering Stop, Sleep or Fail-Safe.
`timescale 1ns/1ps
`include "lintc_defines.vh"
module lintc_top #(
  parameter NCH      = 3,
  parameter WAKE_MIN = `LINTC_WAKE_MIN_CYC,
  parameter WAKE_MAX = `LINTC_WAKE_MAX_CYC,
  parameter DOM_TO   = `LINTC_DOM_TO_CYC,
  parameter FIFO_D   = 16,
  parameter FIFO_AW  = 4
) (
  // Clock and reset
  input  wire           clock_i,
  input  wire           nrst_i,
  // Power mode and supply
  input  wire [2:0]     power_mode_i,
  input  wire           transceiver_supply_uv_i,
  // Channel modes and SPI control bits
  input  wire [2*NCH-1:0] chan_mode_i,
  input  wire           transmit_timeout_enable_i,
  input  wire           low_slope_select_i,
  input  wire           flash_mode_i,
  input  wire           spi_select_n_i,
  input  wire           watchdog_on_bus_wake_enable_i,
  input  wire           watchdog_enabled_i,
  input  wire [NCH-1:0] fault_clear_i,
  input  wire           wake_status_clear_i,
  // Controller side
  input  wire [NCH-1:0] lin_transmit_in_i,
  output reg  [NCH-1:0] lin_receive_out_o,
  output reg            tx_fifo_ready_o,
  // Bus side
  input  wire [NCH-1:0] bus_level_i,
  input  wire           bus_ready_i,
  output reg  [NCH-1:0] bus_drive_dom_o,
  output reg  [NCH-1:0] tx_stage_en_o,
  output reg  [1:0]     slope_o,
  // Status
  output reg            int_n_o,
  output reg            wake_source_status_o,
  output reg  [NCH-1:0] chan_fault_o,
  output reg            watchdog_enable_req_o,
  output reg            restart_req_o
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg  [NCH-1:0] txd_s1_ff;
  reg  [NCH-1:0] txd_s2_ff;
  reg  [NCH-1:0] bus_s1_ff;
  reg  [NCH-1:0] bus_s2_ff;
  reg  [NCH-1:0] bus_d_ff;
  reg            uv_s1_ff;
  reg            uv_s2_ff;
  reg            csn_s1_ff;
  reg            csn_s2_ff;
  reg            csn_d_ff;
  reg  [2:0]     pm_d_ff;

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      txd_s1_ff <= {NCH{1'b1}};
      txd_s2_ff <= {NCH{1'b1}};
      bus_s1_ff <= {NCH{1'b1}};
      bus_s2_ff <= {NCH{1'b1}};
      bus_d_ff  <= {NCH{1'b1}};
      uv_s1_ff  <= 1'b0;
      uv_s2_ff  <= 1'b0;
      csn_s1_ff <= 1'b1;
      csn_s2_ff <= 1'b1;
      csn_d_ff  <= 1'b1;
      pm_d_ff   <= `LINTC_PM_NORMAL;
    end else begin
      txd_s1_ff <= lin_transmit_in_i;
      txd_s2_ff <= txd_s1_ff;
      bus_s1_ff <= bus_level_i;
      bus_s2_ff <= bus_s1_ff;
      bus_d_ff  <= bus_s2_ff;
      uv_s1_ff  <= transceiver_supply_uv_i;
      uv_s2_ff  <= uv_s1_ff;
      csn_s1_ff <= spi_select_n_i;
      csn_s2_ff <= csn_s1_ff;
      csn_d_ff  <= csn_s2_ff;
      pm_d_ff   <= power_mode_i;
    end
  end

  wire csn_rise  = csn_s2_ff & ~csn_d_ff;
  wire pm_normal = (power_mode_i == `LINTC_PM_NORMAL);
  wire pm_stop   = (power_mode_i == `LINTC_PM_STOP);
  wire pm_sleep  = (power_mode_i == `LINTC_PM_SLEEP);
  wire rearm_pm  = (power_mode_i != pm_d_ff) & (pm_stop | pm_sleep |
                   (power_mode_i == `LINTC_PM_FAILSAFE));

  // ----------------------------------------
  // Slope selection
  // ----------------------------------------
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slope_o <= `LINTC_SLOPE_NORMAL;
    end else if (csn_rise && pm_normal) begin
      if (flash_mode_i) begin
        slope_o <= `LINTC_SLOPE_FLASH;
      end else if (low_slope_select_i) begin
        slope_o <= `LINTC_SLOPE_LOW;
      end else begin
        slope_o <= `LINTC_SLOPE_NORMAL;
      end
    end
  end

  // ----------------------------------------
  // Transmit FIFO in front of the drivers
  // ----------------------------------------
  wire           fifo_in_ready;
  wire           fifo_out_valid;
  wire [NCH-1:0] fifo_out_data;

  lintc_fifo #(
    .WIDTH (NCH),
    .DEPTH (FIFO_D),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clock_i     (clock_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (1'b1),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (txd_s2_ff),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (bus_ready_i),
    .out_data_o  (fifo_out_data)
  );

  // ----------------------------------------
  // Per-channel logic
  // ----------------------------------------
  wire [NCH-1:0] wake_evt;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      wire [1:0] mode = chan_mode_i[2*g+1:2*g];
      reg  [1:0] mode_d_ff;
      reg  [31:0] wk_cnt_ff;
      reg        wk_arm_ff;
      reg        woken_ff;
      reg  [31:0] txto_cnt_ff;
      reg        txto_ff;
      reg  [31:0] clamp_cnt_ff;
      wire       txd_dom = ~txd_s2_ff[g];
      wire       bus_dom = ~bus_s2_ff[g];
      wire       bus_fall = bus_d_ff[g] & ~bus_s2_ff[g];
      wire       bus_rise = ~bus_d_ff[g] & bus_s2_ff[g];
      wire       wake_mode = (mode == `LINTC_LM_WAKE);
      wire       drv_mode = (mode == `LINTC_LM_NORMAL) & ~uv_s2_ff;
      wire       clamp_mode = (mode == `LINTC_LM_NORMAL) | (mode == `LINTC_LM_RXONLY);
      wire       wk_ok = (wk_cnt_ff >= WAKE_MIN) & (wk_cnt_ff <= WAKE_MAX);
      wire       tx_hit = transmit_timeout_enable_i & (txto_cnt_ff == DOM_TO - 1);
      wire       clamp_hit = clamp_mode & (clamp_cnt_ff == DOM_TO - 1);

      assign wake_evt[g] = wake_mode & wk_arm_ff & bus_rise & wk_ok;

      always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          mode_d_ff            <= `LINTC_LM_OFF;
          wk_cnt_ff            <= 32'h0;
          wk_arm_ff            <= 1'b1;
          woken_ff             <= 1'b0;
          txto_cnt_ff          <= 32'h0;
          txto_ff              <= 1'b0;
          clamp_cnt_ff         <= 32'h0;
          chan_fault_o[g]      <= 1'b0;
          lin_receive_out_o[g] <= 1'b1;
          bus_drive_dom_o[g]   <= 1'b0;
          tx_stage_en_o[g]     <= 1'b0;
        end else begin
          mode_d_ff <= mode;
          // Dominant phase length for wake filter
          if (bus_fall) begin
            // Fall cycle is the first dominant cycle
            wk_cnt_ff <= 32'h1;
          end else if (bus_dom && wk_cnt_ff <= WAKE_MAX) begin
            wk_cnt_ff <= wk_cnt_ff + 32'h1;
          end
          // Woken state and rearm
          if (wake_evt[g]) begin
            woken_ff  <= 1'b1;
            wk_arm_ff <= 1'b0;
          end else if (mode != mode_d_ff || rearm_pm) begin
            woken_ff  <= 1'b0;
            wk_arm_ff <= 1'b1;
          end
          // Transmit dominant timeout
          if (!txd_dom) begin
            txto_cnt_ff <= 32'h0;
            txto_ff     <= 1'b0;
          end else if (tx_hit) begin
            txto_ff <= 1'b1;
          end else if (txto_cnt_ff < DOM_TO - 1) begin
            txto_cnt_ff <= txto_cnt_ff + 32'h1;
          end
          if (!transmit_timeout_enable_i) begin
            txto_ff <= 1'b0;
          end
          // Bus dominant clamp, mode left untouched
          if (!bus_dom || !clamp_mode) begin
            clamp_cnt_ff <= 32'h0;
          end else if (clamp_cnt_ff < DOM_TO - 1) begin
            clamp_cnt_ff <= clamp_cnt_ff + 32'h1;
          end
          // Sticky fault flag, set wins over clear
          if ((tx_hit & txd_dom & drv_mode) | (clamp_hit & bus_dom)) begin
            chan_fault_o[g] <= 1'b1;
          end else if (fault_clear_i[g]) begin
            chan_fault_o[g] <= 1'b0;
          end
          // Receive output: bus level, high in Off or Wake mode, or low after wake
          if (wake_evt[g] || (woken_ff && wake_mode)) begin
            lin_receive_out_o[g] <= 1'b0;
          end else if (mode == `LINTC_LM_OFF || wake_mode) begin
            lin_receive_out_o[g] <= 1'b1;
          end else begin
            lin_receive_out_o[g] <= bus_s2_ff[g];
          end
          // Driver stage
          tx_stage_en_o[g]   <= drv_mode & ~txto_ff & ~tx_hit;
          bus_drive_dom_o[g] <= drv_mode & ~txto_ff & ~tx_hit & fifo_out_valid & bus_ready_i &
                                ~fifo_out_data[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Wake reporting to the device
  // ----------------------------------------
  wire any_wake = |wake_evt;

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      int_n_o               <= 1'b1;
      wake_source_status_o  <= 1'b0;
      watchdog_enable_req_o <= 1'b0;
      restart_req_o         <= 1'b0;
      tx_fifo_ready_o       <= 1'b0;
    end else begin
      tx_fifo_ready_o <= fifo_in_ready;
      int_n_o         <= ~(any_wake & (pm_stop | pm_normal));
      if (any_wake) begin
        wake_source_status_o <= 1'b1;
      end else if (wake_status_clear_i) begin
        wake_source_status_o <= 1'b0;
      end
      watchdog_enable_req_o <= any_wake & pm_stop & ~watchdog_enabled_i &
                               watchdog_on_bus_wake_enable_i;
      restart_req_o         <= any_wake & pm_sleep;
    end
  end
endmodule

// *** testbench/lintc_bus_model.sv ***
/* LIN bus with a far node: wired dominant with pull-up, drain stall.
   Assumes drive levels from the block and node commands from the bench. */
`timescale 1ns/1ps
module lintc_bus_model #(parameter NCH = 3) (
  // Clock
  input wire           clock_i,
  // Drivers
  input wire [NCH-1:0] drive_dom_i,
  input wire [NCH-1:0] node_dom_i,
  input wire           stall_i,
  // Bus
  output wire [NCH-1:0] bus_level_o,
  output wire           bus_ready_o
);
  // Released bus returns to recessive through the pull-up
  reg stall_ff = 1'b0;
  assign bus_level_o = ~(drive_dom_i | node_dom_i);
  assign bus_ready_o = ~stall_ff;
  always @(posedge clock_i) stall_ff <= stall_i;
endmodule

// *** testbench/lintc_properties.sv ***
/* Port checker of the LIN channel control block.
   Assumes a bind from the testbench top file. */
`timescale 1ns/1ps
`include "lintc_defines.vh"
module lintc_properties #(parameter NCH = 3) (
  // Clock, reset and controls
  input wire           clock_i,
  input wire           nrst_i,
  input wire [2:0]     power_mode_i,
  input wire           transceiver_supply_uv_i,
  input wire           watchdog_on_bus_wake_enable_i,
  input wire [NCH-1:0] fault_clear_i,
  // Outputs watched
  input wire [NCH-1:0] lin_receive_out_o,
  input wire [NCH-1:0] bus_drive_dom_o,
  input wire [NCH-1:0] tx_stage_en_o,
  input wire [1:0]     slope_o,
  input wire           int_n_o,
  input wire           wake_source_status_o,
  input wire [NCH-1:0] chan_fault_o,
  input wire           watchdog_enable_req_o,
  input wire           restart_req_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  property p_int_status; !int_n_o |-> wake_source_status_o; endproperty
  a_int_status: assert property (p_int_status) else $error("interrupt without status");
  property p_int_rx; !int_n_o |-> lin_receive_out_o != {NCH{1'b1}}; endproperty
  a_int_rx: assert property (p_int_rx) else $error("interrupt without receive low");
  property p_sleep_quiet; (power_mode_i == `LINTC_PM_SLEEP) [*3] |-> int_n_o; endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("interrupt in sleep");
  property p_restart; restart_req_o |-> int_n_o && wake_source_status_o; endproperty
  a_restart: assert property (p_restart) else $error("restart request wrong");
  property p_wdog; watchdog_enable_req_o |-> watchdog_on_bus_wake_enable_i && !int_n_o; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog request not enabled");
  property p_uv; transceiver_supply_uv_i [*4] |-> tx_stage_en_o == 0 && bus_drive_dom_o == 0; endproperty
  a_uv: assert property (p_uv) else $error("driver on in undervoltage");
  property p_stage; (bus_drive_dom_o & ~tx_stage_en_o) == 0; endproperty
  a_stage: assert property (p_stage) else $error("drive with stage off");
  property p_hold;
    1 |=> ($past(chan_fault_o & ~fault_clear_i) & ~$past(fault_clear_i, 2) & ~chan_fault_o) == 0;
  endproperty
  a_hold: assert property (p_hold) else $error("fault flag lost");
  property p_slope_hold; (power_mode_i != `LINTC_PM_NORMAL) [*4] |-> $stable(slope_o); endproperty
  a_slope_hold: assert property (p_slope_hold) else $error("slope changed outside normal");
  property p_slope_code; slope_o != 2'h3; endproperty
  a_slope_code: assert property (p_slope_code) else $error("bad slope code");
  c_int: cover property (!int_n_o);
  c_restart: cover property (restart_req_o);
  c_fault: cover property ($rose(chan_fault_o[0]));
endmodule

// *** testbench/testbench.sv ***
/* Self-checking bench of the LIN channel control block.
   Assumes the bus model and the port checker. */
`timescale 1ns/1ps
`include "lintc_defines.vh"
module testbench;
  localparam NCH = 3;
  reg clock_i = 0, nrst_i = 0, transceiver_supply_uv_i = 0, transmit_timeout_enable_i = 1;
  reg low_slope_select_i = 0, flash_mode_i = 0, spi_select_n_i = 1, watchdog_on_bus_wake_enable_i = 0;
  reg watchdog_enabled_i = 1, wake_status_clear_i = 0, stall = 0;
  reg [2:0] power_mode_i = 0, fault_clear_i = 0, lin_transmit_in_i = 3'h7, ndom = 0;
  reg [5:0] chan_mode_i = 0;
  wire [2:0] lin_receive_out_o, bus_level_i, bus_drive_dom_o, tx_stage_en_o, chan_fault_o;
  wire [1:0] slope_o;
  wire tx_fifo_ready_o, bus_ready_i, int_n_o, wake_source_status_o, watchdog_enable_req_o, restart_req_o;
  integer failures = 0, compares = 0, cycles = 0, i;
  reg seen_int, seen_wd, seen_rr, full;
  logic [6:0] rows [5] = '{{`LINTC_PM_NORMAL, 2'b10, `LINTC_SLOPE_LOW}, {`LINTC_PM_NORMAL, 2'b11,
    `LINTC_SLOPE_FLASH}, {`LINTC_PM_STOP, 2'b00, `LINTC_SLOPE_FLASH}, {`LINTC_PM_NORMAL, 2'b00,
    `LINTC_SLOPE_NORMAL}, {`LINTC_PM_SLEEP, 2'b10, `LINTC_SLOPE_NORMAL}};
  lintc_top #(.WAKE_MIN(6), .WAKE_MAX(30), .DOM_TO(50)) dut_u (.*);
  lintc_bus_model #(.NCH(NCH)) bus_u (.clock_i, .drive_dom_i(bus_drive_dom_o), .node_dom_i(ndom),
    .stall_i(stall), .bus_level_o(bus_level_i), .bus_ready_o(bus_ready_i));
  always #2.5 clock_i = ~clock_i;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task cyc(input integer n); repeat (n) @(posedge clock_i); endtask
  task chk(input [31:0] got, input [31:0] exp); begin
    compares = compares + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  end endtask
  task summarize; begin
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  end endtask
  task wake(input integer ch, input integer len); integer k; begin
    seen_int = 0; seen_wd = 0; seen_rr = 0;
    cyc(1); ndom[ch] <= 1'b1; cyc(len); ndom[ch] <= 1'b0;
    for (k = 0; k < 12; k = k + 1) begin
      cyc(1);
      if (!int_n_o) seen_int = 1;
      if (watchdog_enable_req_o) seen_wd = 1;
      if (restart_req_o) seen_rr = 1;
    end
  end endtask
  task clear_all; begin
    cyc(1); fault_clear_i <= 3'h7; wake_status_clear_i <= 1; cyc(1); fault_clear_i <= 0; wake_status_clear_i <= 0;
  end endtask
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin failures = failures + 1; summarize; end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    cyc(3);
    chk(slope_o, `LINTC_SLOPE_NORMAL);
    chk({int_n_o, lin_receive_out_o, chan_fault_o}, 7'h78);
    nrst_i <= 1; cyc(3);
    $display("reset test done");
    for (i = 0; i < 5; i = i + 1) begin
      {power_mode_i, low_slope_select_i, flash_mode_i} <= rows[i][6:2];
      cyc(2); spi_select_n_i <= 0; cyc(3); spi_select_n_i <= 1; cyc(6);
      chk(slope_o, rows[i][1:0]);
    end
    $display("slope table done");
    power_mode_i <= `LINTC_PM_NORMAL; chan_mode_i <= 6'h15; cyc(4);
    wake(0, 15); chk(seen_int, 1);
    chk(lin_receive_out_o[0], 0);
    cyc(20); chk({wake_source_status_o, lin_receive_out_o[0]}, 2'b10);
    wake(1, 5); chk(seen_int, 0);
    wake(2, 31); chk(seen_int, 0);
    wake(1, 6); chk(seen_int, 1);
    wake(2, 30); chk(seen_int, 1);
    wake(0, 15); chk(seen_int, 0);
    chan_mode_i <= 6'h14; cyc(3); chan_mode_i <= 6'h15; cyc(3);
    wake(0, 15); chk(seen_int, 1);
    clear_all; power_mode_i <= `LINTC_PM_STOP; watchdog_on_bus_wake_enable_i <= 1; watchdog_enabled_i <= 0; cyc(4);
    chk(wake_source_status_o, 0);
    wake(1, 15); chk({seen_int, seen_wd}, 2'b11);
    chk(seen_rr, 0);
    clear_all; power_mode_i <= `LINTC_PM_SLEEP; cyc(4);
    wake(2, 15); chk({seen_int, seen_rr}, 2'b01);
    chk({wake_source_status_o, lin_receive_out_o[2]}, 2'b10);
    chk(seen_wd, 0);
    power_mode_i <= `LINTC_PM_FAILSAFE; cyc(4); chk(lin_receive_out_o[2], 1);
    $display("wake tests done");
    power_mode_i <= `LINTC_PM_NORMAL; chan_mode_i <= 6'h3E; clear_all;
    ndom[0] <= 1; cyc(40); chk(chan_fault_o, 0);
    cyc(30); chk(lin_receive_out_o[0], 0);
    ndom[0] <= 0; cyc(4);
    chk(chan_fault_o, 3'h1);
    chk(lin_receive_out_o[0], 1);
    lin_transmit_in_i[1] <= 0; cyc(70);
    chk({tx_stage_en_o[1], bus_drive_dom_o[1]}, 2'b00);
    chk(chan_fault_o[2:1], 2'b01);
    lin_transmit_in_i[1] <= 1; cyc(10);
    chk({tx_stage_en_o[1], chan_fault_o[1]}, 2'b11);
    clear_all; cyc(4); chk(chan_fault_o, 0);
    transmit_timeout_enable_i <= 0; lin_transmit_in_i[2] <= 0; cyc(70);
    chk({tx_stage_en_o[2], bus_drive_dom_o[2]}, 2'b11);
    lin_transmit_in_i[2] <= 1; cyc(10); clear_all;
    $display("fault tests done");
    transceiver_supply_uv_i <= 1; lin_transmit_in_i[1] <= 0; cyc(6);
    chk({tx_stage_en_o[1], bus_drive_dom_o[1]}, 2'b00);
    transceiver_supply_uv_i <= 0; cyc(8);
    chk(bus_drive_dom_o[1], 1);
    lin_transmit_in_i[1] <= 1; cyc(8);
    $display("supply test done");
    stall <= 1; full = 0;
    for (i = 0; i < 40; i = i + 1) begin
      cyc(1); lin_transmit_in_i[1] <= ~lin_transmit_in_i[1];
      if (!tx_fifo_ready_o) full = 1;
    end
    lin_transmit_in_i[1] <= 1; chk(full, 1);
    stall <= 0; i = 0;
    while (!tx_fifo_ready_o && i < 60) begin cyc(1); i = i + 1; end
    cyc(40); chk(tx_fifo_ready_o, 1);
    $display("buffer test done");
    summarize;
  end
endmodule
bind lintc_top lintc_properties #(.NCH(NCH)) chk_u (.clock_i, .nrst_i, .power_mode_i, .transceiver_supply_uv_i,
  .watchdog_on_bus_wake_enable_i, .fault_clear_i, .lin_receive_out_o, .bus_drive_dom_o, .tx_stage_en_o,
  .slope_o, .int_n_o, .wake_source_status_o, .chan_fault_o, .watchdog_enable_req_o, .restart_req_o);
